// ### pin_change_interrupt.sv
// Behaviour
// - Every pin of ports A to D, and bit three of port E, detects edges
// - Change interrupt only while master enable set; irq_o is not gated by it
// - Rise detector gated by rise enable bit
// - Fall detector gated by fall enable bit
// - Both enables set together detect both edge polarities
// - Enabled edge sets pin flag, requests interrupt
// - Summary flag is OR of all flags
// - Edge during clearing write leaves flag set
// - Enabled edge wakes from sleep if enabled
// - Flags updated before wake is signalled
// - Enable registers eight bits, reset zero
// - Port E implements only bit three
// - Flags readable, writable, hardware set, reset zero
`default_nettype none
module pin_change_interrupt
  import pin_change_pkg::*;
#(
  parameter int unsigned PORTS = PORT_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [PORTS*PIN_W-1:0] pins_i,
  input wire logic sleep_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic change_irq_o,
  output logic wake_o,
  output logic irq_o
);

  function automatic logic [PIN_W-1:0] impl_mask(input int unsigned p);
    impl_mask = (p == PORT_E) ? PORT_E_IMPL : FULL_IMPL;
  endfunction

  // One compare shared by every register select
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // Base address of one port's register triple
  function automatic logic [ADDR_W-1:0] port_base(input int unsigned p);
    port_base = ADDR_W'(p * PORT_STRIDE);
  endfunction

  logic [PORTS*PIN_W-1:0] sync_a;
  logic [PORTS*PIN_W-1:0] sync_b;
  logic [PORTS*PIN_W-1:0] sync_c;
  logic [PORTS*PIN_W-1:0] pin_level;
  logic [PORTS*PIN_W-1:0] next_level;
  logic [PORTS*PIN_W-1:0] rise_seen;
  logic [PORTS*PIN_W-1:0] fall_seen;
  logic [PORTS*PIN_W-1:0] rise_edge_enable;
  logic [PORTS*PIN_W-1:0] fall_edge_enable;
  logic [PORTS*PIN_W-1:0] change_flags;
  logic [PORTS*PIN_W-1:0] edge_hit;
  logic [PORTS*PIN_W-1:0] read_mux;
  logic [PORTS-1:0] sel_rise;
  logic [PORTS-1:0] sel_fall;
  logic [PORTS-1:0] sel_flag;
  logic [PORTS-1:0] wr_rise;
  logic [PORTS-1:0] wr_fall;
  logic [PORTS-1:0] wr_flag;
  logic [PORTS-1:0] port_pending;
  logic [PORTS-1:0] port_selected;
  logic sel_core;
  logic sel_mask;
  logic sel_status;
  logic wr_core;
  logic wr_mask;
  logic wr_status;
  logic any_port_sel;
  logic [DATA_W-1:0] core_interrupt_control;
  logic [DATA_W-1:0] next_core;
  logic [1:0] irq_mask;
  logic [1:0] irq_status;
  logic [1:0] irq_event;
  logic [1:0] next_status;
  logic change_irq_master_enable;
  logic change_irq_summary_flag;
  logic any_edge;
  logic wake_req;
  logic [DATA_W-1:0] port_rdata;
  logic [DATA_W-1:0] ctrl_rdata;
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] core_view;

  // Pins are asynchronous; stage one may go metastable
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync_a <= '0;
    end else begin
      sync_a <= pins_i;
    end
  end

  // Only stage two reads stage one
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync_b <= '0;
    end else begin
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync_c <= '0;
    end else begin
      sync_c <= sync_b;
    end
  end

  // A new level counts once stages two and three agree
  for (genvar b = 0; b < PORTS*PIN_W; b++) begin : g_bit
    wire agree = (sync_b[b] == sync_c[b]);
    assign next_level[b] = agree ? sync_c[b] : pin_level[b];
    assign rise_seen[b] = next_level[b] & ~pin_level[b];
    assign fall_seen[b] = ~next_level[b] & pin_level[b];
  end

  // Agreed level of the previous clock, the edge reference
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_level <= '0;
    end else begin
      pin_level <= next_level;
    end
  end

  assign sel_core = addr_is(addr_i, CORE_CTRL_OFS);
  assign sel_mask = addr_is(addr_i, IRQ_MASK_OFS);
  assign sel_status = addr_is(addr_i, IRQ_STATUS_OFS);
  assign wr_core = wr_i & sel_core;
  assign wr_mask = wr_i & sel_mask;
  assign wr_status = wr_i & sel_status;
  assign any_port_sel = |port_selected;

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    localparam logic [PIN_W-1:0] IMPL = impl_mask(p);
    localparam logic [ADDR_W-1:0] BASE = port_base(p);
    localparam logic [ADDR_W-1:0] RISE_ADDR = BASE + RISE_BASE_OFS;
    localparam logic [ADDR_W-1:0] FALL_ADDR = BASE + FALL_BASE_OFS;
    localparam logic [ADDR_W-1:0] FLAG_ADDR = BASE + FLAG_BASE_OFS;
    logic [PIN_W-1:0] rise_q;
    logic [PIN_W-1:0] fall_q;
    logic [PIN_W-1:0] flag_q;
    logic [PIN_W-1:0] hit;
    logic [PIN_W-1:0] wdata_impl;
    logic [PIN_W-1:0] flag_next;

    assign sel_rise[p] = addr_is(addr_i, RISE_ADDR);
    assign sel_fall[p] = addr_is(addr_i, FALL_ADDR);
    assign sel_flag[p] = addr_is(addr_i, FLAG_ADDR);
    assign port_selected[p] = sel_rise[p] | sel_fall[p] | sel_flag[p];
    assign wr_rise[p] = wr_i & sel_rise[p];
    assign wr_fall[p] = wr_i & sel_fall[p];
    assign wr_flag[p] = wr_i & sel_flag[p];
    // Unimplemented bits never store, so they read zero
    assign wdata_impl = wdata_i & IMPL;

    // Set beats the written zero
    for (genvar i = 0; i < PIN_W; i++) begin : g_pin
      localparam int unsigned BIT = p * PIN_W + i;
      wire rise_hit = rise_seen[BIT] & rise_q[i];
      wire fall_hit = fall_seen[BIT] & fall_q[i];
      wire edge_bit = (rise_hit | fall_hit) & IMPL[i];
      wire hold_bit = wr_flag[p] ? wdata_impl[i] : flag_q[i];
      assign hit[i] = edge_bit;
      assign flag_next[i] = hold_bit | edge_bit;
    end

    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        rise_q <= REG_RESET;
      end else begin
        if (wr_rise[p]) begin
          rise_q <= wdata_impl;
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        fall_q <= REG_RESET;
      end else begin
        if (wr_fall[p]) begin
          fall_q <= wdata_impl;
        end
      end
    end

    // Flags keep sampling while the master enable is off
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        flag_q <= REG_RESET;
      end else begin
        flag_q <= flag_next;
      end
    end

    assign rise_edge_enable[p*PIN_W +: PIN_W] = rise_q;
    assign fall_edge_enable[p*PIN_W +: PIN_W] = fall_q;
    assign change_flags[p*PIN_W +: PIN_W] = flag_q;
    assign edge_hit[p*PIN_W +: PIN_W] = hit;
    assign port_pending[p] = |change_flags[p*PIN_W +: PIN_W];
    assign read_mux[p*PIN_W +: PIN_W] =
        sel_rise[p] ? rise_edge_enable[p*PIN_W +: PIN_W] :
        sel_fall[p] ? fall_edge_enable[p*PIN_W +: PIN_W] :
        sel_flag[p] ? change_flags[p*PIN_W +: PIN_W] : REG_RESET;
  end

  // Summary has no storage, so it cannot lag the flags
  assign change_irq_summary_flag = |port_pending;
  assign any_edge = |edge_hit;
  assign change_irq_master_enable = core_interrupt_control[MASTER_EN_BIT];
  // Request follows flags, so a woken core already sees the flag
  assign change_irq_o = change_irq_master_enable & change_irq_summary_flag;
  assign wake_req = sleep_i & change_irq_o;
  assign wake_o = wake_req;

  // Summary bit is read-only; the stored copy stays zero
  assign next_core = wr_core ? {wdata_i[DATA_W-1:SUMMARY_BIT+1], 1'b0} : core_interrupt_control;
  assign core_view = {core_interrupt_control[DATA_W-1:SUMMARY_BIT+1], change_irq_summary_flag};

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      core_interrupt_control <= CORE_RESET;
    end else begin
      core_interrupt_control <= next_core;
    end
  end

  assign irq_event[EV_EDGE] = any_edge;
  assign irq_event[EV_WAKE] = wake_req;
  // Write one to clear, but a new event wins
  for (genvar e = 0; e < 2; e++) begin : g_event
    wire clear_bit = wr_status & wdata_i[e];
    assign next_status[e] = (irq_status[e] & ~clear_bit) | irq_event[e];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_mask <= IRQ_RESET;
    end else begin
      if (wr_mask) begin
        irq_mask <= wdata_i[1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_status <= IRQ_RESET;
    end else begin
      irq_status <= next_status;
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  always_comb begin
    port_rdata = '0;
    for (int p = 0; p < PORTS; p++) begin
      port_rdata = port_rdata | read_mux[p*PIN_W +: PIN_W];
    end
  end

  assign ctrl_rdata = sel_core ? core_view :
                      sel_mask ? {6'h00, irq_mask} :
                      sel_status ? {6'h00, irq_status} : 8'h00;
  assign next_rdata = any_port_sel ? port_rdata : ctrl_rdata;

  // Unmapped addresses read zero; data stands one cycle only
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
    end
  end

endmodule // pin_change_interrupt
`default_nettype wire

// ### pin_change_interrupt_tb_top.sv
`default_nettype none
module pin_change_interrupt_tb_top
  import pin_change_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = '0, rst_b_i = '0, sleep_i = '0, wr_i = '0, rd_i = '0, rd_d = '0;
  logic [4:0] addr_i = '0;
  logic [7:0] wdata_i = '0, rdata_o, q[$];
  logic [39:0] pins_i, rv;
  logic change_irq_o, wake_o, irq_o;
  logic [31:0] seed = 32'h4;
  int err_count = 0, check_count = 0;
  always #2 clk_i = ~clk_i;
  pin_driver pin_driver_i (.clk_i, .pins_o(pins_i));
  pin_change_interrupt pin_change_interrupt_i (.*);
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(string n, logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  // A gap cycle after each strobe keeps one assignment per step
  task automatic wr(logic [4:0] a, logic [7:0] d);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_i) wr_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(logic [4:0] a, logic [7:0] e);
    {addr_i, rd_i} <= {a, 1'b1};
    q.push_back(e);
    @(posedge clk_i) rd_i <= '0;
    @(posedge clk_i);
  endtask
  // Sampled at the next edge, so drives stay on the rising edge
  task automatic lv(logic [2:0] e);
    @(posedge clk_i);
    chk("levels", {5'h00, irq_o, wake_o, change_irq_o}, {5'h00, e});
  endtask
  always @(posedge clk_i) begin
    rd_d <= rd_i;
    if (rd_d) chk("rdata", rdata_o, q.pop_front());
  end
  task automatic test_done();
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= '1;
    @(posedge clk_i);
    for (int a = 0; a < 18; a++) rd(5'(a), 8'h00);
    rd(5'h1f, 8'h00);
    wr(RISE_BASE_OFS, 8'h0f);
    wr(FALL_BASE_OFS, 8'h3c);
    for (int n = 3; n < 15; n++) if (n % 3 != 2) wr(5'(n), 8'hff);
    rd(5'h0c, PORT_E_IMPL);
    rd(5'h04, 8'hff);
    wr(IRQ_MASK_OFS, 8'h03);
    seed = xs(seed);
    rv = {seed, seed[7:0] | 8'h04};
    pin_driver_i.drive(rv);
    repeat (4) @(posedge clk_i);
    rd(FLAG_BASE_OFS, rv[7:0] & 8'h0f);
    lv(3'b100);
    pin_driver_i.drive('0);
    repeat (4) @(posedge clk_i);
    rd(FLAG_BASE_OFS, rv[7:0] & 8'h3f);
    for (int n = 1; n < 5; n++) rd(5'(3 * n + 2), rv[8 * n +: 8] & (n == 4 ? PORT_E_IMPL : 8'hff));
    rd(CORE_CTRL_OFS, 8'h01);
    wr(CORE_CTRL_OFS, 8'h08);
    lv(3'b101);
    sleep_i <= '1;
    lv(3'b111);
    sleep_i <= '0;
    wr(IRQ_MASK_OFS, 8'h00);
    lv(3'b001);
    rd(IRQ_STATUS_OFS, 8'h03);
    wr(IRQ_STATUS_OFS, 8'h03);
    wr(IRQ_MASK_OFS, 8'h03);
    lv(3'b001);
    pin_driver_i.drive(40'h1);
    repeat (2) @(posedge clk_i);
    // Known set bits masked out; a new edge lands on this write
    wr(FLAG_BASE_OFS, 8'h00);
    rd(FLAG_BASE_OFS, 8'h01);
    wr(CORE_CTRL_OFS, 8'h00);
    lv(3'b100);
    repeat (2) @(posedge clk_i);
    test_done();
  end
  initial begin
    #40000 err_count++;
    test_done();
  end
endmodule // pin_change_interrupt_tb_top
`default_nettype wire

// ### pin_change_pkg.sv
`default_nettype none
package pin_change_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIN_W = 8;
  // Ports A, B, C, D, E in that order
  localparam int unsigned PORT_COUNT = 5;
  localparam int unsigned PORT_E = 4;
  // Port n: rise at 3n, fall at 3n+1, flags at 3n+2
  localparam logic [ADDR_W-1:0] RISE_BASE_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] FALL_BASE_OFS = 5'h01;
  localparam logic [ADDR_W-1:0] FLAG_BASE_OFS = 5'h02;
  localparam logic [ADDR_W-1:0] PORT_STRIDE = 5'h03;
  localparam logic [ADDR_W-1:0] CORE_CTRL_OFS = 5'h0f;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 5'h10;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 5'h11;
  // Field positions in core_interrupt_control
  localparam int unsigned MASTER_EN_BIT = 3;
  localparam int unsigned SUMMARY_BIT = 0;
  // Only bit 3 exists on port E
  localparam logic [PIN_W-1:0] PORT_E_IMPL = 8'h08;
  localparam logic [PIN_W-1:0] FULL_IMPL = 8'hff;
  localparam logic [PIN_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CORE_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // Status layout: bit 0 edge seen, bit 1 wake request
  localparam int unsigned EV_EDGE = 0;
  localparam int unsigned EV_WAKE = 1;
  localparam int unsigned SYNC_STAGES = 3;
endpackage
`default_nettype wire

// ### pin_change_sva.sv
`default_nettype none
module pin_change_sva
  import pin_change_pkg::*;
#(parameter int unsigned PORTS = PORT_COUNT) (
  input wire logic clk_i, rst_b_i, sleep_i, wr_i, rd_i, change_irq_o, wake_o, irq_o,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [PORTS*PIN_W-1:0] pins_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_wake_gate:
    assert property (wake_o == (sleep_i && change_irq_o)) else $error("wake");
  a_read_idle:
    assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata idle");
  a_summary_read:
    assert property (rd_i && addr_i == CORE_CTRL_OFS |=> (rdata_o[MASTER_EN_BIT] &
      rdata_o[SUMMARY_BIT]) == $past(change_irq_o)) else $error("summary");
  a_port_e_bits:
    assert property (rd_i && addr_i >= 5'h0c && addr_i <= 5'h0e |=> (rdata_o & ~PORT_E_IMPL) == 8'h00)
      else $error("port e");
  // Sync stages plus agreement filter: a rise traces back to a pin move
  a_change_cause:
    assert property ($rose(change_irq_o) |-> $past(wr_i) || $past(pins_i, 4) != $past(pins_i, 5))
      else $error("cause");
  a_change_sticky:
    assert property (change_irq_o && !wr_i |=> change_irq_o) else $error("sticky");
  a_irq_sticky:
    assert property (irq_o && !wr_i |=> irq_o) else $error("irq");
  a_reset_quiet:
    assert property ($rose(rst_b_i) |-> !change_irq_o && !irq_o) else $error("reset");
  c_wake: cover property (wake_o);
  c_irq_only: cover property (irq_o && !change_irq_o);
  c_summary: cover property (rd_i && addr_i == CORE_CTRL_OFS);
endmodule // pin_change_sva
bind pin_change_interrupt pin_change_sva #(.PORTS(PORTS)) pin_change_sva_i (.*);
`default_nettype wire

// ### pin_driver.sv
`default_nettype none
module pin_driver
  import pin_change_pkg::*;
(
  input wire logic clk_i,
  output logic [PORT_COUNT*PIN_W-1:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins_o = '0;
  // Pins move just after an edge, never beside it
  task automatic drive(logic [PORT_COUNT*PIN_W-1:0] v);
    pins_o <= v;
    @(posedge clk_i);
  endtask
endmodule // pin_driver
`default_nettype wire
